// File: rtl/codec_output_path_pdm_ctrl.sv
//Contract
//RULE1: Serial input direct or via converter
//RULE2: Two DAC channels, 24-bit samples
//RULE3: Per-channel attenuation, 0.375 dB steps
//RULE4: Two-channel modulator on one line
//RULE5: Stream timed by own clock output
//RULE6: Saturate modulator input at -6 dBFS
//RULE7: Stored byte replaces audio in pattern
//RULE8: Control register: enable, channel select
//RULE9: Software keeps byte during pattern
//RULE10: Software sends byte 128 times
//RULE11: Amplifier command bytes, software's choice
//RULE12: Headphone enables per side
//RULE13: Software waits 6 ms before unmute
//RULE14: Precharge on at reset, low-power bits
//RULE15: Software mutes before path changes
//RULE16: Single-ended: negative pins powered down
//RULE17: Two output, one input converter
//RULE18: Output converters take up to 192k
//RULE19: Fixed 0.75 in, 1.33 out
//RULE20: Core output limited to -2.5 dBFS
//RULE21: Core four in, four out, 32
//RULE22: ADC data and pulse share pin
//RULE23: Byte repeated MSB first, gapless
//RULE24: Attenuation change at sample boundary
`default_nettype none
module codec_output_path_pdm_ctrl
    import out_path_pkg::*;
#(
    parameter int DIV = BIT_CLOCK_OUTPUT_PIN_DIV
)(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic sample_stb, // Sample boundary pulse
    input wire logic signed [SAMPLE_W-1:0] serial_in_l, // Serial input left
    input wire logic signed [SAMPLE_W-1:0] serial_in_r, // Serial input right
    input wire logic signed [SAMPLE_W-1:0] rateconv_l, // Converted left
    input wire logic signed [SAMPLE_W-1:0] rateconv_r, // Converted right
    input wire logic serial_adc_data, // ADC serial data bit
    output logic signed [SAMPLE_W-1:0] core_in_l, // To core left
    output logic signed [SAMPLE_W-1:0] core_in_r, // To core right
    output logic signed [SAMPLE_W-1:0] serial_out_l, // Serial out left
    output logic signed [SAMPLE_W-1:0] serial_out_r, // Serial out right
    output logic signed [SAMPLE_W-1:0] dac_l, // DAC left sample
    output logic signed [SAMPLE_W-1:0] dac_r, // DAC right sample
    output logic bit_clock_output_pin, // Modulator clock out
    output logic pulse_data_pin, // Shared data pin
    output logic left_headphone_driver_on, // Left headphone driver
    output logic right_headphone_driver_on, // Right headphone driver
    output logic [PRECHARGE_PINS-1:0] output_precharge_lowpower // Precharge low power
);
    logic [ATTEN_W-1:0] att_l_ff;
    logic [ATTEN_W-1:0] att_r_ff;
    logic [BYTE_W-1:0] prech_ff;
    logic [BYTE_W-1:0] pctrl_ff;
    logic [BYTE_W-1:0] pbyte_ff;
    logic [BYTE_W-1:0] hpsel_ff;
    logic [BYTE_W-1:0] route_ff;
    logic [$clog2(DIV)-1:0] div_ff;
    logic [2:0] bit_ff;
    logic [SAMPLE_W-1:0] lsamp_ff;
    logic [SAMPLE_W-1:0] rsamp_ff;
    logic [SAMPLE_W+1:0] acc_l_ff;
    logic [SAMPLE_W+1:0] acc_r_ff;
    logic pdm_l_ff;
    logic pdm_r_ff;
    logic adc_s1_ff;
    logic adc_s2_ff;
    logic pat_ff;
    logic [7:0] pat_reps_ff;
    logic signed [SAMPLE_W-1:0] core_l;
    logic signed [SAMPLE_W-1:0] core_r;
    logic signed [SAMPLE_W-1:0] dac_src_l;
    logic signed [SAMPLE_W-1:0] dac_src_r;
    logic signed [SAMPLE_W-1:0] att_out_l;
    logic signed [SAMPLE_W-1:0] att_out_r;
    logic signed [SAMPLE_W-1:0] clip_l;
    logic signed [SAMPLE_W-1:0] clip_r;
    logic [7:0] idx;
    logic wr_en;
    logic hit;
    logic half_en;
    logic clk_fall;
    logic [31:0] nxt_rd;

    //------------------------------------------------
    // Register bus
    //------------------------------------------------
    assign idx = paddr[9:2];
    assign wr_en = psel && penable && pwrite;
    always_comb begin
        hit = 1'b1;
        nxt_rd = '0;
        case (idx)
            IDX_PRECHARGE: nxt_rd[7:0] = prech_ff;
            IDX_DAC_LEFT: nxt_rd[7:0] = att_l_ff;
            IDX_DAC_RIGHT: nxt_rd[7:0] = att_r_ff;
            IDX_PULSE_CTRL: nxt_rd[7:0] = pctrl_ff;
            IDX_PULSE_BYTE: nxt_rd[7:0] = pbyte_ff;
            IDX_HP_SELECT: nxt_rd[7:0] = hpsel_ff;
            IDX_ROUTE: nxt_rd[7:0] = route_ff;
            IDX_STATUS: nxt_rd[7:0] = {pat_ff, pat_reps_ff[7:1]};
            IDX_DAC_IN: nxt_rd[SAMPLE_W-1:0] = dac_l;
            default: hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
            hit = 1'b0;
        end
    end

    // Answer in the access cycle with no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && hit && !pwrite) ? nxt_rd : '0;
        end
    end

    // RULE14: Precharge on at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prech_ff <= RST_PRECHARGE;
            att_l_ff <= RST_ATTEN;
            att_r_ff <= RST_ATTEN;
            pctrl_ff <= RST_PULSE_CTRL;
            pbyte_ff <= RST_PULSE_BYTE;
            hpsel_ff <= RST_HP_SELECT;
            route_ff <= RST_ROUTE;
        end else if (wr_en && pready && !pslverr) begin
            case (idx)
                IDX_PRECHARGE: prech_ff <= pwdata[7:0];
                IDX_DAC_LEFT: att_l_ff <= pwdata[7:0];
                IDX_DAC_RIGHT: att_r_ff <= pwdata[7:0];
                IDX_PULSE_CTRL: pctrl_ff <= pwdata[7:0];
                IDX_PULSE_BYTE: pbyte_ff <= pwdata[7:0];
                IDX_HP_SELECT: hpsel_ff <= pwdata[7:0];
                IDX_ROUTE: route_ff <= pwdata[7:0];
                default: route_ff <= route_ff;
            endcase
        end
    end

    //------------------------------------------------
    // Analog output control
    //------------------------------------------------
    // RULE12: Headphone side enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_headphone_driver_on <= 1'b0;
            right_headphone_driver_on <= 1'b0;
            output_precharge_lowpower <= '0;
        end else begin
            left_headphone_driver_on <= hpsel_ff[HP_L_BIT];
            right_headphone_driver_on <= hpsel_ff[HP_R_BIT];
            // RULE14: Per-pin low-power bits
            output_precharge_lowpower <= prech_ff[PRECHARGE_PINS-1:0];
        end
    end

    //------------------------------------------------
    // Routing
    //------------------------------------------------
    // RULE17: Converter outputs enter here
    // RULE18: Converter rates set outside
    // RULE1: Direct or converted input
    assign core_l = route_ff[RT_RATECONV_BIT] ? rateconv_l : serial_in_l;
    assign core_r = route_ff[RT_RATECONV_BIT] ? rateconv_r : serial_in_r;
    assign dac_src_l = route_ff[RT_DAC_SRC_BIT] ? core_in_r : core_in_l;
    assign dac_src_r = core_in_r;

    // RULE19: Fixed scaling left to converters
    // RULE21: Core input pair registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_in_l <= '0;
            core_in_r <= '0;
            serial_out_l <= '0;
            serial_out_r <= '0;
        end else if (sample_stb) begin
            core_in_l <= core_l;
            core_in_r <= core_r;
            serial_out_l <= core_in_l;
            serial_out_r <= core_in_r;
        end
    end

    // RULE2: Two 24-bit DAC channels
    atten_chan u_att_l (
        .pclk(pclk),
        .presetn(presetn),
        .atten(att_l_ff),
        .sample_stb(sample_stb),
        .din(dac_src_l),
        .dout(att_out_l)
    );
    atten_chan u_att_r (
        .pclk(pclk),
        .presetn(presetn),
        .atten(att_r_ff),
        .sample_stb(sample_stb),
        .din(dac_src_r),
        .dout(att_out_r)
    );
    assign dac_l = att_out_l;
    assign dac_r = att_out_r;

    //------------------------------------------------
    // Pulse density modulator
    //------------------------------------------------
    // RULE6: Saturate at -6 dBFS
    assign clip_l = (core_in_l > $signed(CLIP_POS)) ? $signed(CLIP_POS) :
                    (core_in_l < $signed(CLIP_NEG)) ? $signed(CLIP_NEG) : core_in_l;
    assign clip_r = (core_in_r > $signed(CLIP_POS)) ? $signed(CLIP_POS) :
                    (core_in_r < $signed(CLIP_NEG)) ? $signed(CLIP_NEG) : core_in_r;

    // RULE5: Own clock output divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
            bit_clock_output_pin <= 1'b0;
        end else if (half_en) begin
            div_ff <= '0;
            bit_clock_output_pin <= !bit_clock_output_pin;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign half_en = (div_ff == $bits(div_ff)'(DIV/2 - 1));
    assign clk_fall = half_en && bit_clock_output_pin;

    // First-order modulators, one per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_l_ff <= '0;
            acc_r_ff <= '0;
            lsamp_ff <= '0;
            rsamp_ff <= '0;
            pdm_l_ff <= 1'b0;
            pdm_r_ff <= 1'b0;
        end else if (clk_fall) begin
            lsamp_ff <= clip_l ^ 24'h800000;
            rsamp_ff <= clip_r ^ 24'h800000;
            acc_l_ff <= {1'b0, acc_l_ff[SAMPLE_W:0]} + {2'h0, lsamp_ff} -
                        (acc_l_ff[SAMPLE_W] ? {2'h1, 24'h000000} : '0);
            acc_r_ff <= {1'b0, acc_r_ff[SAMPLE_W:0]} + {2'h0, rsamp_ff} -
                        (acc_r_ff[SAMPLE_W] ? {2'h1, 24'h000000} : '0);
            pdm_l_ff <= acc_l_ff[SAMPLE_W];
            pdm_r_ff <= acc_r_ff[SAMPLE_W];
        end
    end

    // RULE23: Byte repeated MSB first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_ff <= BIT_MSB;
            pat_ff <= 1'b0;
            pat_reps_ff <= '0;
        end else if (clk_fall) begin
            pat_ff <= pctrl_ff[PC_EN_BIT];
            if (!pctrl_ff[PC_EN_BIT]) begin
                bit_ff <= BIT_MSB;
                pat_reps_ff <= '0;
            end else if (!pat_ff) begin
                // First byte starts at its MSB
                bit_ff <= BIT_MSB;
            end else begin
                bit_ff <= bit_ff - 3'h1;
                if (bit_ff == 3'h0 && pat_reps_ff != 8'hFF) begin
                    pat_reps_ff <= pat_reps_ff + 8'h01;
                end
            end
        end
    end

    // RULE22: Shared pin; RULE4: channels on one line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_s1_ff <= 1'b0;
            adc_s2_ff <= 1'b0;
            pulse_data_pin <= 1'b0;
        end else begin
            adc_s1_ff <= serial_adc_data;
            adc_s2_ff <= adc_s1_ff;
            if (!route_ff[RT_PULSE_PIN_BIT]) begin
                pulse_data_pin <= adc_s2_ff;
            end else if (half_en) begin
                // RULE7: Byte replaces selected channel; RULE8: channel select
                if (!bit_clock_output_pin) begin
                    pulse_data_pin <= (pat_ff && pctrl_ff[PC_CHAN_BIT] == PSLOT_RIGHT[0]) ?
                                      pbyte_ff[bit_ff] : pdm_r_ff;
                end else begin
                    pulse_data_pin <= (pat_ff && pctrl_ff[PC_CHAN_BIT] == PSLOT_LEFT[0]) ?
                                      pbyte_ff[bit_ff] : pdm_l_ff;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/out_path_pkg.sv
`default_nettype none
package out_path_pkg;
    // Register indices; the byte address is the index times four
    localparam logic [7:0] IDX_PRECHARGE = 8'h29;
    localparam logic [7:0] IDX_DAC_LEFT = 8'h2F;
    localparam logic [7:0] IDX_DAC_RIGHT = 8'h30;
    localparam logic [7:0] IDX_PULSE_CTRL = 8'h36;
    localparam logic [7:0] IDX_PULSE_BYTE = 8'h37;
    localparam logic [7:0] IDX_HP_SELECT = 8'h43;
    localparam logic [7:0] IDX_ROUTE = 8'h50;
    localparam logic [7:0] IDX_STATUS = 8'h51;
    localparam logic [7:0] IDX_DAC_IN = 8'h52;
    // Reset values
    localparam logic [7:0] RST_PRECHARGE = 8'h00;
    localparam logic [7:0] RST_ATTEN = 8'h00;
    localparam logic [7:0] RST_PULSE_CTRL = 8'h00;
    localparam logic [7:0] RST_PULSE_BYTE = 8'h00;
    localparam logic [7:0] RST_HP_SELECT = 8'h00;
    localparam logic [7:0] RST_ROUTE = 8'h00;
    // Field positions
    localparam int PC_EN_BIT = 0;
    localparam int PC_CHAN_BIT = 1;
    localparam int HP_L_BIT = 0;
    localparam int HP_R_BIT = 1;
    localparam int RT_RATECONV_BIT = 0;
    localparam int RT_PULSE_PIN_BIT = 1;
    localparam int RT_DAC_SRC_BIT = 2;
    localparam int PRECHARGE_PINS = 4;
    // Data path
    localparam int SAMPLE_W = 24;
    localparam int ATTEN_W = 8;
    // Wide gain word keeps the deepest setting accurate after 255 steps
    localparam int GAIN_W = 32;
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 32'h80000000;
    // Steps of 0.375 dB: one step multiplies by 10^(-0.375/20)
    localparam logic [GAIN_W-1:0] GAIN_STEP = 32'h7A976562;
    // -6 dBFS saturation level for the modulator input
    localparam logic [SAMPLE_W-1:0] CLIP_POS = 24'h4026E6;
    localparam logic [SAMPLE_W-1:0] CLIP_NEG = 24'hBFD91A;
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_MSB = 3'h7;
    localparam int BIT_CLOCK_OUTPUT_PIN_DIV = 16;
    localparam logic [1:0] PSLOT_LEFT = 2'h0;
    localparam logic [1:0] PSLOT_RIGHT = 2'h1;
endpackage
`default_nettype wire

// File: rtl/atten_chan.sv
`default_nettype none
module atten_chan
    import out_path_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic [ATTEN_W-1:0] atten, // Attenuation steps
    input wire logic sample_stb, // Sample boundary
    input wire logic signed [SAMPLE_W-1:0] din, // Input sample
    output logic signed [SAMPLE_W-1:0] dout // Attenuated sample
);
    logic [ATTEN_W-1:0] cur_ff;
    logic [ATTEN_W-1:0] cnt_ff;
    logic [GAIN_W-1:0] gain_ff;
    logic [GAIN_W-1:0] work_ff;
    logic busy_ff;
    logic [2*GAIN_W-1:0] prod;
    logic signed [SAMPLE_W+GAIN_W:0] mul;

    assign prod = work_ff * GAIN_STEP;
    assign mul = din * $signed({1'b0, gain_ff});

    // RULE3: Gain from step count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= RST_ATTEN;
            work_ff <= GAIN_UNITY;
            busy_ff <= 1'b0;
            cur_ff <= RST_ATTEN;
        end else if (!busy_ff && atten != cur_ff) begin
            cur_ff <= atten;
            cnt_ff <= atten;
            work_ff <= GAIN_UNITY;
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            if (cnt_ff == RST_ATTEN) begin
                busy_ff <= 1'b0;
            end else begin
                work_ff <= prod[2*GAIN_W-2:GAIN_W-1];
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end

    // RULE24: Gain swap on boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_ff <= GAIN_UNITY;
        end else if (sample_stb && !busy_ff && atten == cur_ff) begin
            gain_ff <= work_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= '0;
        end else if (sample_stb) begin
            dout <= mul[SAMPLE_W+GAIN_W-2:GAIN_W-1];
        end
    end
endmodule
`default_nettype wire

// File: testbench/codec_output_path_pdm_ctrl_asserts.sv
`default_nettype none
module codec_output_path_pdm_ctrl_asserts
    import out_path_pkg::*;
#(
    parameter int DIV = BIT_CLOCK_OUTPUT_PIN_DIV
)(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic sample_stb, // Boundary
    input wire logic signed [SAMPLE_W-1:0] dac_l, // DAC left
    input wire logic bit_clock_output_pin, // Stream clock
    input wire logic left_headphone_driver_on, // Left driver
    input wire logic [PRECHARGE_PINS-1:0] output_precharge_lowpower // Low power
);
    localparam logic [11:0] A_HP = {2'h0, IDX_HP_SELECT, 2'h0};
    localparam logic [11:0] A_PRE = {2'h0, IDX_PRECHARGE, 2'h0};
    logic hit;
    logic bck_q_ff;
    logic seen_ff;
    logic [7:0] run_ff;
    assign hit = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && (paddr[9:2] inside
        {IDX_PRECHARGE, IDX_DAC_LEFT, IDX_DAC_RIGHT, IDX_PULSE_CTRL, IDX_PULSE_BYTE,
        IDX_HP_SELECT, IDX_ROUTE, IDX_STATUS, IDX_DAC_IN});
    // ----------
    // Cycles at present bit clock level
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck_q_ff <= 1'b0;
            seen_ff <= 1'b0;
            run_ff <= 8'h00;
        end else begin
            bck_q_ff <= bit_clock_output_pin;
            seen_ff <= seen_ff | (bit_clock_output_pin != bck_q_ff);
            run_ff <= (bit_clock_output_pin != bck_q_ff) ? 8'h01 : run_ff + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_err_decode: assert property (pready |-> pslverr == !hit)
        else $error("error flag wrong for address");
    a_hp_write: assert property (pready && pwrite && paddr == A_HP
        |-> ##2 left_headphone_driver_on == $past(pwdata[HP_L_BIT], 2))
        else $error("headphone enable not taken");
    a_lowpower_write: assert property (pready && pwrite && paddr == A_PRE
        |-> ##2 output_precharge_lowpower == $past(pwdata[3:0], 2))
        else $error("precharge bits not taken");
    a_bck_half: assert property (seen_ff |-> run_ff <= DIV / 2 &&
        (bit_clock_output_pin == bck_q_ff || run_ff == DIV / 2))
        else $error("bit clock half period wrong");
    a_dac_boundary: assert property ($changed(dac_l) |-> $past(sample_stb))
        else $error("DAC sample changed off boundary");
    c_refused: cover property (pready && pslverr);
    c_hp_on: cover property (pready && pwrite && paddr == A_HP && pwdata[HP_L_BIT]);
    c_dac_move: cover property ($changed(dac_l));
endmodule
bind codec_output_path_pdm_ctrl codec_output_path_pdm_ctrl_asserts #(.DIV(DIV)) i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sample_stb, .dac_l, .bit_clock_output_pin, .left_headphone_driver_on,
    .output_precharge_lowpower
);
`default_nettype wire

// File: testbench/pdm_amp_model.sv
`default_nettype none
module pdm_amp_model (
    input wire logic pclk, // Helper clock
    input wire logic bit_clock_output_pin, // Stream clock
    input wire logic pulse_data_pin, // Stream data
    input wire logic listen_right, // Own slot
    output logic [7:0] cmd_byte, // Last command
    output int reps // Gapless repeats
);
    timeunit 1ns;
    timeprecision 100ps;
    logic bck_q = 1'b0;
    logic pin_q = 1'b0;
    logic [7:0] sr = 8'h00;
    logic [7:0] nxt;
    int since = 0;
    initial begin
        cmd_byte = 8'h00;
        reps = 0;
    end
    // slot bits at stream clock edges
    always @(posedge pclk) begin
        bck_q <= bit_clock_output_pin;
        pin_q <= pulse_data_pin;
        if (bit_clock_output_pin != bck_q && bit_clock_output_pin != listen_right) begin
            // Data as it stood at the clock edge
            nxt = {sr[6:0], pin_q};
            sr <= nxt;
            if (nxt inside {8'hAC, 8'hD8, 8'hD4, 8'hD2, 8'hD1, 8'hE1, 8'hE2, 8'hE4}) begin
                reps <= (nxt == cmd_byte && since == 7) ? reps + 1 : 1;
                cmd_byte <= nxt;
                since <= 0;
            end else begin
                since <= since + 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/codec_output_path_pdm_ctrl_tb.sv
`default_nettype none
module codec_output_path_pdm_ctrl_tb import out_path_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DV = 4;
    logic pclk, presetn, psel, penable, pwrite, sample_stb, serial_adc_data, listen_right;
    logic pready, pslverr, err, bck, pin, hp_l, hp_r;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] lowp;
    logic [7:0] amp_cmd;
    logic signed [SAMPLE_W-1:0] sil, sir, rcl, rcr, cil, cir, dl, dr, sol, sor;
    int amp_reps, err_total, n_checks, cyc, stb_cnt;
    codec_output_path_pdm_ctrl #(.DIV(DV)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sample_stb, .serial_in_l(sil), .serial_in_r(sir), .rateconv_l(rcl),
        .rateconv_r(rcr), .serial_adc_data, .core_in_l(cil), .core_in_r(cir),
        .serial_out_l(sol), .serial_out_r(sor), .dac_l(dl), .dac_r(dr),
        .bit_clock_output_pin(bck), .pulse_data_pin(pin), .left_headphone_driver_on(hp_l),
        .right_headphone_driver_on(hp_r), .output_precharge_lowpower(lowp)
    );
    pdm_amp_model i_amp (
        .pclk, .bit_clock_output_pin(bck), .pulse_data_pin(pin), .listen_right,
        .cmd_byte(amp_cmd), .reps(amp_reps)
    );
    // ----------
    // Clock, boundary pulse, watchdog
    // ----------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        stb_cnt <= (stb_cnt == 299) ? 0 : stb_cnt + 1;
        sample_stb <= (stb_cnt == 299);
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            err_total++;
            $display("[ERR] %0t run too long", $time);
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input logic signed [23:0] got, input real exp);
        n_checks++;
        if ($isunknown(got) || ($itor(got) - exp) ** 2 > (exp * 0.01 + 2.0) ** 2) begin
            err_total++;
            $display("[ERR] %0t level %0d exp %0f", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        input logic [1:0] lo = 2'h0);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, lo};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_stb(input int k);
        repeat (k) @(posedge pclk iff sample_stb);
        @(posedge pclk);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_regs();
        logic [7:0] idx [6] = '{IDX_PRECHARGE, IDX_DAC_LEFT, IDX_DAC_RIGHT, IDX_PULSE_CTRL,
            IDX_PULSE_BYTE, IDX_HP_SELECT};
        logic [7:0] val [6] = '{8'h0A, 8'hA5, 8'h5A, 8'h02, 8'hC3, 8'h03};
        chk({28'h0, lowp}, 32'h0);
        foreach (idx[i]) begin
            apb(1'b0, idx[i], 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, idx[i], {24'h0, val[i]});
            apb(1'b0, idx[i], 32'h0);
            chk(rd, {24'h0, val[i]});
        end
        chk({30'h0, hp_r, hp_l}, 32'h3);
        chk({28'h0, lowp}, 32'hA);
        apb(1'b0, 8'h44, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, IDX_DAC_LEFT, 32'hFF, 2'h2);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, IDX_DAC_LEFT, 32'h0);
        chk(rd, 32'hA5);
        $display("registers done");
    endtask
    task automatic t_route();
        apb(1'b1, IDX_DAC_LEFT, 32'hFF);
        apb(1'b1, IDX_DAC_RIGHT, 32'hFF);
        apb(1'b1, IDX_ROUTE, 32'h0);
        wait_stb(2);
        chk(cil, sil);
        apb(1'b1, IDX_ROUTE, 32'h1);
        wait_stb(2);
        chk(cil, rcl);
        chk(cir, rcr);
        chk(sol, rcl);
        chk(sor, rcr);
        $display("routing done");
    endtask
    task automatic t_atten();
        int st [3] = '{16, 255, 1};
        apb(1'b1, IDX_ROUTE, 32'h0);
        apb(1'b1, IDX_DAC_LEFT, 32'h0);
        apb(1'b1, IDX_DAC_RIGHT, 32'h0);
        wait_stb(3);
        chk(dl, sil);
        chk(dr, sir);
        apb(1'b0, IDX_DAC_IN, 32'h0);
        chk(rd, {8'h0, sil});
        apb(1'b1, IDX_ROUTE, 32'h4);
        wait_stb(2);
        chk(dl, sir);
        apb(1'b1, IDX_ROUTE, 32'h0);
        foreach (st[i]) begin
            apb(1'b1, IDX_DAC_LEFT, st[i]);
            apb(1'b1, IDX_DAC_RIGHT, st[i]);
            wait_stb(3);
            chk_near(dl, $itor(sil) * 10.0 ** (-0.375 * st[i] / 20.0));
            chk_near(dr, $itor(sir) * 10.0 ** (-0.375 * st[i] / 20.0));
        end
        $display("attenuation done");
    endtask
    task automatic t_adc();
        apb(1'b1, IDX_ROUTE, 32'h0);
        serial_adc_data <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({31'h0, pin}, 32'h1);
        serial_adc_data <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({31'h0, pin}, 32'h0);
        $display("shared pin done");
    endtask
    task automatic t_pattern();
        logic [7:0] cmd [8] = '{8'hAC, 8'hD8, 8'hD4, 8'hD2, 8'hD1, 8'hE1, 8'hE2, 8'hE4};
        int n;
        apb(1'b1, IDX_ROUTE, 32'h2);
        foreach (cmd[i]) begin
            apb(1'b1, IDX_PULSE_CTRL, 32'h0);
            apb(1'b1, IDX_PULSE_BYTE, {24'h0, cmd[i]});
            listen_right <= i[0];
            apb(1'b1, IDX_PULSE_CTRL, {30'h0, i[0], 1'b1});
            n = 0;
            while (!(amp_cmd === cmd[i] && amp_reps >= 128) && n < 6000) begin
                @(posedge pclk);
                n++;
            end
            apb(1'b0, IDX_STATUS, 32'h0);
            chk({30'h0, rd[7], rd[6:0] >= 7'h40}, 32'h3);
            chk({24'h0, amp_cmd}, {24'h0, cmd[i]});
            chk({31'h0, amp_reps >= 128}, 32'h1);
        end
        apb(1'b1, IDX_PULSE_CTRL, 32'h0);
        $display("pattern done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, serial_adc_data, listen_right} = 6'h0;
        {paddr, pwdata, err_total, n_checks, cyc, stb_cnt} = '0;
        {sil, sir, rcl, rcr} = {24'h3FFFFF, 24'h200000, 24'h0ABCDE, 24'hF12345};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_route();
        t_atten();
        t_adc();
        t_pattern();
        end_of_test();
    end
endmodule
`default_nettype wire
